// ===== hdl/fpec_ctrl.sv
// flash program/erase control register, key unlock and operation sequencer
//
// Notes on behaviour
// - control guard resets set, software-set only, blocks writes
// - correct control key pair clears control guard
// - control keys must come as an exact pair
// - wrong key sequence locks guard until reset
// - option guard resets set, locks option bits
// - option keys must come as an exact pair
// - reload bit requests reset, hardware clears when done
// - reload bit writes ignored while option guard set
// - violation flag with fault enable raises interrupt
// - done flag with done enable raises interrupt
// - done flag set only when done enable is on
// - busy set at start, cleared at end or error
// - program start bit cleared after busy drops
// - option start bit cleared after busy drops
// - option update erases page then programs with complements
// - sector select picks one 8 KB sector erase
// - sector erase skips info memory and protected sectors
// - mass select picks whole main array erase
// - mass erase spares info memory, refused under protection
// - page select picks page erase
// - program select picks program operation
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module fpec_ctrl
  import fpec_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // flash array side
  output logic             array_cmd_valid,
  output logic [2:0]       array_cmd,
  output logic             array_write_complement,
  input  wire logic        array_cmd_done,
  input  wire logic        array_fault,
  input  wire logic        target_is_info,
  input  wire logic        sector_protected,
  input  wire logic        protect_any_active,
  // option reload
  output logic             option_reload_reset_req,
  input  wire logic        option_load_done,
  // interrupt
  output logic             flash_irq
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic        access_done;
  logic        wr_key;
  logic        wr_optkey;
  logic        wr_status;
  logic        wr_control;
  logic        addr_mapped;
  logic [31:0] prdata_q;

  assign access_done = psel && penable;
  assign addr_mapped = (paddr == FPEC_OFF_KEY) || (paddr == FPEC_OFF_OPTKEY)
                       || (paddr == FPEC_OFF_STATUS) || (paddr == FPEC_OFF_CONTROL);
  assign wr_key      = access_done && pwrite && (paddr == FPEC_OFF_KEY);
  assign wr_optkey   = access_done && pwrite && (paddr == FPEC_OFF_OPTKEY);
  assign wr_status   = access_done && pwrite && (paddr == FPEC_OFF_STATUS);
  assign wr_control  = access_done && pwrite && (paddr == FPEC_OFF_CONTROL);
  assign pready      = 1'b1;
  assign pslverr     = access_done && !addr_mapped;
  assign prdata      = prdata_q;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic           guard_q;
  logic           opt_guard_q;
  logic           reload_q;
  logic           fault_ie_q;
  logic           done_ie_q;
  logic           prog_start_q;
  logic           opt_start_q;
  logic           sector_sel_q;
  logic           mass_sel_q;
  logic           page_sel_q;
  logic           program_sel_q;
  logic           busy_q;
  logic           violation_q;
  logic           done_q;
  logic           ctrl_unlock;
  logic           opt_unlock;
  logic           ctrl_failed;
  logic           opt_failed;
  logic           ctrl_wr_ok;
  logic           launch_prog;
  logic           launch_opt;
  logic           set_violation;
  logic           set_done;
  logic           finish_clear;
  logic           is_opt_q;
  fpec_state_type state_q;
  logic [31:0]    control_word;
  logic [31:0]    status_word;

  assign ctrl_wr_ok  = wr_control && !guard_q;
  assign launch_prog = ctrl_wr_ok && pwdata[FPEC_CR_PROG_START] && !prog_start_q
                       && !opt_start_q && (state_q == FPEC_IDLE);
  assign launch_opt  = ctrl_wr_ok && !opt_guard_q && pwdata[FPEC_CR_OPT_START]
                       && !opt_start_q && !prog_start_q && !launch_prog
                       && (state_q == FPEC_IDLE);

  // ----------------------------------------------------------------
  // key sequences
  // ----------------------------------------------------------------
  fpec_key_seq #(
    .KEY_FIRST  (FPEC_CTRL_KEY_FIRST),
    .KEY_SECOND (FPEC_CTRL_KEY_SECOND)
  ) u_ctrl_keys (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .key_write    (wr_key),
    .key_data     (pwdata),
    .unlock_pulse (ctrl_unlock),
    .seq_failed   (ctrl_failed)
  );

  fpec_key_seq #(
    .KEY_FIRST  (FPEC_OPT_KEY_FIRST),
    .KEY_SECOND (FPEC_OPT_KEY_SECOND)
  ) u_opt_keys (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .key_write    (wr_optkey),
    .key_data     (pwdata),
    .unlock_pulse (opt_unlock),
    .seq_failed   (opt_failed)
  );

  // ----------------------------------------------------------------
  // guard bits
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      guard_q <= FPEC_CR_RESET[FPEC_CR_GUARD];
    end else if (ctrl_wr_ok && pwdata[FPEC_CR_GUARD]) begin
      guard_q <= 1'b1;
    end else if (ctrl_unlock && !ctrl_failed) begin
      guard_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      opt_guard_q <= FPEC_CR_RESET[FPEC_CR_OPT_GUARD];
    end else if (ctrl_wr_ok && pwdata[FPEC_CR_OPT_GUARD]) begin
      opt_guard_q <= 1'b1;
    end else if (opt_unlock && !opt_failed) begin
      opt_guard_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // option reload request
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reload_q <= FPEC_CR_RESET[FPEC_CR_RELOAD];
    end else if (ctrl_wr_ok && !opt_guard_q && pwdata[FPEC_CR_RELOAD]) begin
      reload_q <= 1'b1;
    end else if (option_load_done) begin
      reload_q <= 1'b0;
    end
  end

  assign option_reload_reset_req = reload_q;

  // ----------------------------------------------------------------
  // enables and operation selects
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      fault_ie_q <= FPEC_CR_RESET[FPEC_CR_FAULT_IE];
      done_ie_q  <= FPEC_CR_RESET[FPEC_CR_DONE_IE];
    end else if (ctrl_wr_ok) begin
      fault_ie_q <= pwdata[FPEC_CR_FAULT_IE];
      done_ie_q  <= pwdata[FPEC_CR_DONE_IE];
    end
  end

  // selects are frozen while an operation runs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sector_sel_q  <= FPEC_CR_RESET[FPEC_CR_SECTOR];
      mass_sel_q    <= FPEC_CR_RESET[FPEC_CR_MASS];
      page_sel_q    <= FPEC_CR_RESET[FPEC_CR_PAGE];
      program_sel_q <= FPEC_CR_RESET[FPEC_CR_PROGRAM];
    end else if (ctrl_wr_ok && (state_q == FPEC_IDLE)) begin
      sector_sel_q  <= pwdata[FPEC_CR_SECTOR];
      mass_sel_q    <= pwdata[FPEC_CR_MASS];
      page_sel_q    <= pwdata[FPEC_CR_PAGE];
      program_sel_q <= pwdata[FPEC_CR_PROGRAM];
    end
  end

  // ----------------------------------------------------------------
  // start bits
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prog_start_q <= FPEC_CR_RESET[FPEC_CR_PROG_START];
    end else if (launch_prog) begin
      prog_start_q <= 1'b1;
    end else if (finish_clear) begin
      prog_start_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      opt_start_q <= FPEC_CR_RESET[FPEC_CR_OPT_START];
    end else if (launch_opt) begin
      opt_start_q <= 1'b1;
    end else if (finish_clear) begin
      opt_start_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  logic       issue_valid;
  logic [2:0] issue_cmd;
  logic       issue_refused;
  logic       issue_skip;
  logic       any_sel;

  assign any_sel = program_sel_q || page_sel_q || sector_sel_q || mass_sel_q;

  // pick the command from the frozen selects; program wins if several are set
  always_comb begin
    issue_cmd     = FPEC_CMD_PROGRAM;
    issue_refused = 1'b0;
    issue_skip    = 1'b0;
    if (program_sel_q) begin
      issue_cmd = FPEC_CMD_PROGRAM;
    end else if (page_sel_q) begin
      issue_cmd = FPEC_CMD_PAGE_ERASE;
    end else if (sector_sel_q) begin
      issue_cmd     = FPEC_CMD_SECT_ERASE;
      issue_refused = sector_protected;
      issue_skip    = target_is_info;
    end else begin
      issue_cmd     = FPEC_CMD_MASS_ERASE;
      issue_refused = protect_any_active;
    end
  end

  assign finish_clear = (state_q == FPEC_FINISH);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q  <= FPEC_IDLE;
      is_opt_q <= 1'b0;
    end else begin
      case (state_q)
        FPEC_IDLE: begin
          if (prog_start_q) begin
            if (!any_sel || issue_refused || issue_skip) begin
              state_q <= FPEC_FINISH;
            end else begin
              state_q  <= FPEC_RUN;
              is_opt_q <= 1'b0;
            end
          end else if (opt_start_q) begin
            state_q  <= FPEC_RUN;
            is_opt_q <= 1'b1;
          end
        end
        FPEC_RUN: begin
          if (array_fault) begin
            state_q <= FPEC_FINISH;
          end else if (array_cmd_done) begin
            state_q <= is_opt_q ? FPEC_OPT_PROG : FPEC_FINISH;
          end
        end
        FPEC_OPT_PROG: begin
          if (array_fault || array_cmd_done) begin
            state_q <= FPEC_FINISH;
          end
        end
        FPEC_FINISH: begin
          state_q <= FPEC_IDLE;
        end
        default: begin
          state_q <= FPEC_IDLE;
        end
      endcase
    end
  end

  // command strobe to the array
  always_comb begin
    issue_valid = 1'b0;
    if ((state_q == FPEC_IDLE) && prog_start_q) begin
      issue_valid = any_sel && !issue_refused && !issue_skip;
    end else if ((state_q == FPEC_IDLE) && opt_start_q) begin
      issue_valid = 1'b1;
    end else if ((state_q == FPEC_RUN) && is_opt_q && array_cmd_done && !array_fault) begin
      issue_valid = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      array_cmd_valid <= 1'b0;
      array_cmd       <= FPEC_CMD_PROGRAM;
    end else begin
      array_cmd_valid <= issue_valid;
      if (issue_valid) begin
        if (state_q == FPEC_RUN) begin
          array_cmd <= FPEC_CMD_OPT_PROG;
        end else if (opt_start_q && !prog_start_q) begin
          array_cmd <= FPEC_CMD_OPT_ERASE;
        end else begin
          array_cmd <= issue_cmd;
        end
      end
    end
  end

  // complement copies accompany every option byte program step
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      array_write_complement <= 1'b0;
    end else begin
      array_write_complement <= (state_q == FPEC_OPT_PROG)
                                || ((state_q == FPEC_RUN) && is_opt_q && array_cmd_done);
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  assign set_violation = ((state_q == FPEC_IDLE) && prog_start_q && any_sel && issue_refused)
                         || (((state_q == FPEC_RUN) || (state_q == FPEC_OPT_PROG))
                             && array_fault);
  assign set_done      = done_ie_q && !array_fault
                         && (((state_q == FPEC_RUN) && !is_opt_q && array_cmd_done)
                             || ((state_q == FPEC_OPT_PROG) && array_cmd_done));

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy_q <= 1'b0;
    end else if (issue_valid && (state_q == FPEC_IDLE)) begin
      busy_q <= 1'b1;
    end else if ((state_q == FPEC_RUN) && (array_fault || (array_cmd_done && !is_opt_q))) begin
      busy_q <= 1'b0;
    end else if ((state_q == FPEC_OPT_PROG) && (array_fault || array_cmd_done)) begin
      busy_q <= 1'b0;
    end
  end

  // hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      violation_q <= 1'b0;
    end else if (set_violation) begin
      violation_q <= 1'b1;
    end else if (wr_status && pwdata[FPEC_SR_VIOLATION]) begin
      violation_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      done_q <= 1'b0;
    end else if (set_done) begin
      done_q <= 1'b1;
    end else if (wr_status && pwdata[FPEC_SR_DONE]) begin
      done_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flash_irq <= 1'b0;
    end else begin
      flash_irq <= (violation_q && fault_ie_q)
                   || (done_q && done_ie_q);
    end
  end

  // ----------------------------------------------------------------
  // read data, loaded in the setup cycle
  // ----------------------------------------------------------------
  always_comb begin
    control_word                     = 32'h00000000;
    control_word[FPEC_CR_GUARD]      = guard_q;
    control_word[FPEC_CR_OPT_GUARD]  = opt_guard_q;
    control_word[FPEC_CR_RELOAD]     = reload_q;
    control_word[FPEC_CR_FAULT_IE]   = fault_ie_q;
    control_word[FPEC_CR_DONE_IE]    = done_ie_q;
    control_word[FPEC_CR_PROG_START] = prog_start_q;
    control_word[FPEC_CR_OPT_START]  = opt_start_q;
    control_word[FPEC_CR_SECTOR]     = sector_sel_q;
    control_word[FPEC_CR_MASS]       = mass_sel_q;
    control_word[FPEC_CR_PAGE]       = page_sel_q;
    control_word[FPEC_CR_PROGRAM]    = program_sel_q;
    status_word                      = 32'h00000000;
    status_word[FPEC_SR_BUSY]        = busy_q;
    status_word[FPEC_SR_VIOLATION]   = violation_q;
    status_word[FPEC_SR_DONE]        = done_q;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prdata_q <= 32'h00000000;
    end else if (psel && !penable) begin
      if (paddr == FPEC_OFF_CONTROL) begin
        prdata_q <= control_word;
      end else if (paddr == FPEC_OFF_STATUS) begin
        prdata_q <= status_word;
      end else begin
        prdata_q <= 32'h00000000;
      end
    end
  end

endmodule
`default_nettype wire

// ===== hdl/fpec_key_seq.sv
// two-word key sequence detector with a fault latch held until reset
`timescale 1ns/100ps
`default_nettype none
module fpec_key_seq #(
  parameter logic [31:0] KEY_FIRST  = 32'h0,
  parameter logic [31:0] KEY_SECOND = 32'h0
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // key writes
  input  wire logic        key_write,
  input  wire logic [31:0] key_data,
  // results
  output logic             unlock_pulse,
  output logic             seq_failed
);

  logic first_seen_q;
  logic failed_q;

  // ----------------------------------------------------------------
  // sequence tracking
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      first_seen_q <= 1'b0;
    end else if (key_write) begin
      first_seen_q <= !first_seen_q && !failed_q && (key_data == KEY_FIRST);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      failed_q <= 1'b0;
    end else if (key_write) begin
      if (first_seen_q ? (key_data != KEY_SECOND) : (key_data != KEY_FIRST)) begin
        failed_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      unlock_pulse <= 1'b0;
    end else begin
      unlock_pulse <= key_write && first_seen_q && !failed_q
                      && (key_data == KEY_SECOND);
    end
  end

  assign seq_failed = failed_q;

endmodule
`default_nettype wire

// ===== hdl/fpec_pkg.sv
// constants shared by the flash program/erase control block
package fpec_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] FPEC_OFF_KEY     = 8'h08;
  localparam logic [7:0] FPEC_OFF_OPTKEY  = 8'h0C;
  localparam logic [7:0] FPEC_OFF_STATUS  = 8'h10;
  localparam logic [7:0] FPEC_OFF_CONTROL = 8'h14;

  // ----------------------------------------------------------------
  // unlock keys
  // ----------------------------------------------------------------
  localparam logic [31:0] FPEC_CTRL_KEY_FIRST  = 32'h45670123;
  localparam logic [31:0] FPEC_CTRL_KEY_SECOND = 32'hCDEF89AB;
  localparam logic [31:0] FPEC_OPT_KEY_FIRST   = 32'h08192A3B;
  localparam logic [31:0] FPEC_OPT_KEY_SECOND  = 32'h4C5D6E7F;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int unsigned FPEC_CR_GUARD      = 31;
  localparam int unsigned FPEC_CR_OPT_GUARD  = 30;
  localparam int unsigned FPEC_CR_RELOAD     = 27;
  localparam int unsigned FPEC_CR_FAULT_IE   = 25;
  localparam int unsigned FPEC_CR_DONE_IE    = 24;
  localparam int unsigned FPEC_CR_PROG_START = 19;
  localparam int unsigned FPEC_CR_OPT_START  = 17;
  localparam int unsigned FPEC_CR_SECTOR     = 11;
  localparam int unsigned FPEC_CR_MASS       = 2;
  localparam int unsigned FPEC_CR_PAGE       = 1;
  localparam int unsigned FPEC_CR_PROGRAM    = 0;
  localparam logic [31:0] FPEC_CR_RESET      = 32'hC0000000;

  // ----------------------------------------------------------------
  // status word fields
  // ----------------------------------------------------------------
  localparam int unsigned FPEC_SR_BUSY       = 16;
  localparam int unsigned FPEC_SR_VIOLATION  = 4;
  localparam int unsigned FPEC_SR_DONE       = 0;

  // ----------------------------------------------------------------
  // array commands
  // ----------------------------------------------------------------
  localparam logic [2:0] FPEC_CMD_PROGRAM    = 3'h0;
  localparam logic [2:0] FPEC_CMD_PAGE_ERASE = 3'h1;
  localparam logic [2:0] FPEC_CMD_SECT_ERASE = 3'h2;
  localparam logic [2:0] FPEC_CMD_MASS_ERASE = 3'h3;
  localparam logic [2:0] FPEC_CMD_OPT_ERASE  = 3'h4;
  localparam logic [2:0] FPEC_CMD_OPT_PROG   = 3'h5;

  // ----------------------------------------------------------------
  // sequencer states, gray along the option update path
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FPEC_IDLE     = 2'h0,
    FPEC_RUN      = 2'h1,
    FPEC_OPT_PROG = 2'h3,
    FPEC_FINISH   = 2'h2
  } fpec_state_type;

endpackage

// ===== tb/fpec_ctrl_monitor.sv
// port checker for the flash program/erase control block
`timescale 1ns/100ps
`default_nettype none
module fpec_ctrl_monitor
  import fpec_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        reset,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // array and reload
  input wire logic        array_cmd_valid,
  input wire logic [2:0]  array_cmd,
  input wire logic        array_write_complement,
  input wire logic        target_is_info,
  input wire logic        sector_protected,
  input wire logic        protect_any_active,
  input wire logic        option_reload_reset_req,
  input wire logic        option_load_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic       mapped;
  logic [2:0] last_cmd_q;
  assign mapped = paddr inside {FPEC_OFF_KEY, FPEC_OFF_OPTKEY, FPEC_OFF_STATUS, FPEC_OFF_CONTROL};
  // remembers the previous array command
  always_ff @(posedge sys_clk) begin
    if (reset) last_cmd_q <= 3'h7;
    else if (array_cmd_valid) last_cmd_q <= array_cmd;
  end
  // ----
  // properties
  // ----
  property p_unmapped;
    psel && penable && !mapped |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_pulse;
    array_cmd_valid |=> !array_cmd_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("command strobe longer than one cycle");
  property p_comp;
    array_cmd_valid && array_cmd == FPEC_CMD_OPT_PROG |-> array_write_complement;
  endproperty
  a_comp: assert property (p_comp) else $error("option program without complement");
  property p_comp_low;
    array_cmd_valid && array_cmd != FPEC_CMD_OPT_PROG |-> !array_write_complement;
  endproperty
  a_comp_low: assert property (p_comp_low) else $error("complement outside option program");
  property p_order;
    array_cmd_valid && array_cmd == FPEC_CMD_OPT_PROG |-> last_cmd_q == FPEC_CMD_OPT_ERASE;
  endproperty
  a_order: assert property (p_order) else $error("option program not after page erase");
  property p_sector;
    array_cmd_valid && array_cmd == FPEC_CMD_SECT_ERASE |->
      !$past(target_is_info) && !$past(sector_protected);
  endproperty
  a_sector: assert property (p_sector) else $error("sector erase on guarded target");
  property p_mass;
    array_cmd_valid && array_cmd == FPEC_CMD_MASS_ERASE |-> !$past(protect_any_active);
  endproperty
  a_mass: assert property (p_mass) else $error("mass erase under protection");
  property p_reload_hold;
    option_reload_reset_req && !option_load_done && !$past(option_load_done)
      |=> option_reload_reset_req;
  endproperty
  a_reload_hold: assert property (p_reload_hold) else $error("reload request dropped early");
  property p_reload_clear;
    option_load_done && !(psel && penable && pwrite) |-> ##[1:2] !option_reload_reset_req;
  endproperty
  a_reload_clear: assert property (p_reload_clear) else $error("reload request not cleared");
endmodule
bind fpec_ctrl fpec_ctrl_monitor u_mon (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr,
  .prdata, .pslverr, .array_cmd_valid, .array_cmd, .array_write_complement, .target_is_info,
  .sector_protected, .protect_any_active, .option_reload_reset_req, .option_load_done);
`default_nettype wire

// ===== tb/fpec_ctrl_tb.sv
// self-checking bench for the flash program/erase control block
`timescale 1ns/100ps
`default_nettype none
module fpec_ctrl_tb
  import fpec_pkg::*;
;
  logic        sys_clk = 1'h0, reset = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        array_cmd_done = 1'h0, array_fault = 1'h0, target_is_info = 1'h0;
  logic        sector_protected = 1'h0, protect_any_active = 1'h0, option_load_done = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, array_cmd_valid, array_write_complement, err;
  logic        option_reload_reset_req, flash_irq;
  logic [2:0]  array_cmd;
  logic [15:0] lfsr_q = 16'hA4D0;
  logic [31:0] sel [5] = '{32'h80001, 32'h80002, 32'h80800, 32'h80004, 32'h20000};
  int          bad_count = 0, compares = 0;
  always #2 sys_clk = ~sys_clk;
  fpec_ctrl dut (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .array_cmd_valid, .array_cmd, .array_write_complement,
    .array_cmd_done, .array_fault, .target_is_info, .sector_protected, .protect_any_active,
    .option_reload_reset_req, .option_load_done, .flash_irq);
  // ----
  // helpers
  // ----
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk);
    psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin @(posedge sys_clk); n++; end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    chk("ready_wait", 32'h1, 32'(n));
    psel <= 1'h0; penable <= 1'h0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask
  task automatic wcmd(input logic [2:0] c);
    while (array_cmd_valid !== 1'h1) @(negedge sys_clk);
    chk("cmd", {29'h0, c}, {29'h0, array_cmd});
    chk("comp", {31'h0, c == FPEC_CMD_OPT_PROG}, {31'h0, array_write_complement});
    rchk(FPEC_OFF_STATUS, 32'h00010000);
    @(posedge sys_clk);
    array_cmd_done <= 1'h1;
    @(posedge sys_clk);
    array_cmd_done <= 1'h0;
  endtask
  task automatic run(input logic [31:0] d, input logic [2:0] c);
    apb(1'h1, FPEC_OFF_CONTROL, d);
    wcmd(c);
    if (c == FPEC_CMD_OPT_ERASE) wcmd(FPEC_CMD_OPT_PROG);
    repeat (3) @(posedge sys_clk);
    rchk(FPEC_OFF_STATUS, {31'h0, d[24]});
    rchk(FPEC_OFF_CONTROL, d & ~32'h000A0000);
    chk("irq", {31'h0, d[24]}, {31'h0, flash_irq});
    apb(1'h1, FPEC_OFF_STATUS, 32'h00000011);
  endtask
  task automatic deny(input logic [31:0] d, input logic [31:0] e);
    apb(1'h1, FPEC_OFF_CONTROL, d);
    repeat (4) @(posedge sys_clk);
    rchk(FPEC_OFF_STATUS, e);
    chk("irq", {31'h0, e[4] & d[25]}, {31'h0, flash_irq});
    apb(1'h1, FPEC_OFF_STATUS, 32'h00000011);
    apb(1'h1, FPEC_OFF_CONTROL, 32'h0);
  endtask
  task automatic complete_run;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'h0;
    rchk(FPEC_OFF_CONTROL, FPEC_CR_RESET);
    apb(1'h0, 8'h04, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'h1, FPEC_OFF_CONTROL, 32'h09000007);
    rchk(FPEC_OFF_CONTROL, FPEC_CR_RESET);
    apb(1'h1, FPEC_OFF_KEY, FPEC_CTRL_KEY_FIRST);
    apb(1'h1, FPEC_OFF_KEY, FPEC_CTRL_KEY_SECOND);
    repeat (2) @(posedge sys_clk);
    rchk(FPEC_OFF_CONTROL, 32'h40000000);
    apb(1'h1, FPEC_OFF_OPTKEY, FPEC_OPT_KEY_FIRST);
    apb(1'h1, FPEC_OFF_OPTKEY, FPEC_OPT_KEY_SECOND);
    repeat (2) @(posedge sys_clk);
    rchk(FPEC_OFF_CONTROL, 32'h0);
    foreach (sel[i]) begin
      lfsr_q = lfsr_next(lfsr_q);
      run(sel[i] | {7'h0, lfsr_q[0], 24'h0}, 3'(i));
    end
    lfsr_q = lfsr_next(lfsr_q);
    sector_protected <= 1'h1;
    deny(32'h00080800 | {6'h0, lfsr_q[0], 25'h0}, 32'h10);
    sector_protected <= 1'h0;
    protect_any_active <= 1'h1;
    deny(32'h02080004, 32'h10);
    protect_any_active <= 1'h0;
    target_is_info <= 1'h1;
    deny(32'h02080800, 32'h0);
    target_is_info <= 1'h0;
    apb(1'h1, FPEC_OFF_CONTROL, 32'h08000000);
    @(negedge sys_clk);
    chk("reload", 32'h1, {31'h0, option_reload_reset_req});
    @(posedge sys_clk);
    option_load_done <= 1'h1;
    @(posedge sys_clk);
    option_load_done <= 1'h0;
    repeat (2) @(posedge sys_clk);
    rchk(FPEC_OFF_CONTROL, 32'h0);
    apb(1'h1, FPEC_OFF_CONTROL, 32'h40000000);
    apb(1'h1, FPEC_OFF_CONTROL, 32'h08000000);
    rchk(FPEC_OFF_CONTROL, 32'h40000000);
    chk("reload", 32'h0, {31'h0, option_reload_reset_req});
    apb(1'h1, FPEC_OFF_CONTROL, 32'h80000000);
    apb(1'h1, FPEC_OFF_KEY, FPEC_CTRL_KEY_FIRST);
    apb(1'h1, FPEC_OFF_KEY, {16'h0, lfsr_q});
    apb(1'h1, FPEC_OFF_KEY, FPEC_CTRL_KEY_FIRST);
    apb(1'h1, FPEC_OFF_KEY, FPEC_CTRL_KEY_SECOND);
    repeat (2) @(posedge sys_clk);
    rchk(FPEC_OFF_CONTROL, FPEC_CR_RESET);
    complete_run;
  end
  // watchdog: 20000 cycles, far above the expected run of a few hundred cycles
  initial begin
    #80000;
    bad_count++;
    complete_run;
  end
endmodule
`default_nettype wire
